// *** hw/ifsm_sync.sv ***
// Two-flop synchroniser for asynchronous pin inputs
module ifsm_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// First stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// Idle pin levels, so no false edge follows release
			meta_reg <= INIT;
			q        <= INIT;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// *** hw/ifsm_top.sv ***
// Two-wire serial slave fronting a 512-byte nonvolatile array
module ifsm_top #(
	parameter logic [3:0] DEV_TYPE = 4'h3 // Arbitrary type code
) (
	input  wire logic                      mclk,
	input  wire logic                      rst_n,
	input  wire logic                      scl_in,
	input  wire logic                      sda_in,
	output logic                           sda_out,
	output logic                           sda_oe,
	input  wire logic [ifsm_pkg::SEL_W-1:0] chip_select_pins,
	input  wire logic                      wr_lock
);
	import ifsm_pkg::*;

	logic [SYNC_W-1:0] raw_in;
	logic [SYNC_W-1:0] sync_q;
	logic              scl_s;
	logic              sda_s;
	logic [SEL_W-1:0]  sel_s;
	logic              lock_s;
	logic              scl_d_reg;
	logic              sda_d_reg;
	logic              scl_rise;
	logic              scl_fall;
	logic              start_det;
	logic              stop_det;
	logic              sel_match;
	logic              edge_ok;

	ifsm_state_t       state_reg;
	logic [3:0]        bit_reg;
	logic [BYTE_W-1:0] shift_reg;
	logic [BYTE_W-1:0] tx_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic              page_reg;
	logic              rw_reg;
	logic              mack_reg;
	logic              sda_oe_reg;
	logic              sda_out_reg;

	logic [BYTE_W-1:0] mem_reg [MEM_DEPTH];
	logic [ADDR_W-1:0] rd_ptr;
	logic [BYTE_W-1:0] rd_byte;
	logic              wr_fire;
	logic              wr_en;

	// Pull-downs on the pins make floating inputs arrive low
	assign raw_in = {scl_in, sda_in, chip_select_pins, wr_lock};

	// Three mclk samples per edge, far inside a 1 MHz half period
	ifsm_sync #(
		.W    (SYNC_W),
		.INIT ({1'b1, 1'b1, {SEL_W{1'b0}}, 1'b0})
	) u_sync (
		.clk   (mclk),
		.rst_n (rst_n),
		.d     (raw_in),
		.q     (sync_q)
	);

	assign {scl_s, sda_s, sel_s, lock_s} = sync_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	// Edges decoded only from synchronised samples
	assign scl_rise  = scl_s & ~scl_d_reg;
	assign scl_fall  = ~scl_s & scl_d_reg;
	assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	assign edge_ok   = ~start_det & ~stop_det;

	assign sel_match =
		(shift_reg[SA_TYPE_MSB:SA_TYPE_LSB] == DEV_TYPE) &&
		(shift_reg[SA_SEL_MSB:SA_SEL_LSB] == sel_s);

	// Read pointer: page from slave byte, low bits from latch
	assign rd_ptr = (state_reg == ST_ADDR) ?
		{page_reg, addr_reg[BYTE_W-1:0]} : addr_reg;
	assign rd_byte = mem_reg[rd_ptr];

	assign wr_fire = edge_ok && scl_fall && (state_reg == ST_WDATA) &&
		(bit_reg == BIT_ACK);
	assign wr_en = wr_fire && !lock_s;

	// No reset on the array: contents are meant to persist
	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem_reg[addr_reg] <= shift_reg;
		end
	end

	// Open-drain: only a low is ever driven
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sda_out_reg <= 1'b0;
		end else begin
			sda_out_reg <= 1'b0;
		end
	end

	assign sda_out = sda_out_reg;
	assign sda_oe  = sda_oe_reg;

	// Byte engine; start and stop take priority over clock edges
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg  <= ST_IDLE;
			bit_reg    <= BIT_ZERO;
			shift_reg  <= BYTE_RESET;
			tx_reg     <= BYTE_RESET;
			addr_reg   <= ADDR_RESET;
			page_reg   <= 1'b0;
			rw_reg     <= 1'b0;
			mack_reg   <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else if (start_det) begin
			state_reg  <= ST_ADDR;
			bit_reg    <= BIT_ZERO;
			sda_oe_reg <= 1'b0;
		end else if (stop_det) begin
			state_reg  <= ST_IDLE;
			bit_reg    <= BIT_ZERO;
			sda_oe_reg <= 1'b0;
		end else if (scl_rise) begin
			case (state_reg)
				ST_ADDR, ST_WORD, ST_WDATA: begin
					if (bit_reg < BIT_ACK) begin
						shift_reg <= {shift_reg[BYTE_W-2:0], sda_s};
						bit_reg   <= bit_reg + 4'h1;
					end else if (bit_reg == BIT_ACK) begin
						bit_reg <= BIT_END;
					end
				end
				ST_RDATA: begin
					if (bit_reg < BIT_ACK) begin
						bit_reg <= bit_reg + 4'h1;
					end else if (bit_reg == BIT_ACK) begin
						mack_reg <= ~sda_s;
						bit_reg  <= BIT_END;
					end
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (state_reg)
				ST_ADDR: begin
					if (bit_reg == BIT_ACK) begin
						if (sel_match) begin
							sda_oe_reg <= 1'b1;
							page_reg   <= shift_reg[SA_PAGE_BIT];
							rw_reg     <= shift_reg[SA_RW_BIT];
						end else begin
							state_reg <= ST_IDLE;
							bit_reg   <= BIT_ZERO;
						end
					end else if (bit_reg == BIT_END) begin
						bit_reg <= BIT_ZERO;
						if (rw_reg == RW_READ) begin
							state_reg  <= ST_RDATA;
							addr_reg   <= rd_ptr;
							tx_reg     <= rd_byte;
							sda_oe_reg <= ~rd_byte[BYTE_W-1];
						end else begin
							state_reg  <= ST_WORD;
							sda_oe_reg <= 1'b0;
						end
					end
				end
				ST_WORD: begin
					if (bit_reg == BIT_ACK) begin
						addr_reg   <= {page_reg, shift_reg};
						sda_oe_reg <= 1'b1;
					end else if (bit_reg == BIT_END) begin
						state_reg  <= ST_WDATA;
						bit_reg    <= BIT_ZERO;
						sda_oe_reg <= 1'b0;
					end
				end
				ST_WDATA: begin
					// Locked writes are still acknowledged
					if (bit_reg == BIT_ACK) begin
						addr_reg   <= next_addr(addr_reg);
						sda_oe_reg <= 1'b1;
					end else if (bit_reg == BIT_END) begin
						bit_reg    <= BIT_ZERO;
						sda_oe_reg <= 1'b0;
					end
				end
				ST_RDATA: begin
					if ((bit_reg != BIT_ZERO) && (bit_reg < BIT_ACK)) begin
						tx_reg     <= {tx_reg[BYTE_W-2:0], 1'b0};
						sda_oe_reg <= ~tx_reg[BYTE_W-2];
					end else if (bit_reg == BIT_ACK) begin
						sda_oe_reg <= 1'b0;
						addr_reg   <= next_addr(addr_reg);
					end else if (bit_reg == BIT_END) begin
						bit_reg <= BIT_ZERO;
						if (mack_reg) begin
							tx_reg     <= rd_byte;
							sda_oe_reg <= ~rd_byte[BYTE_W-1];
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				default: begin
					sda_oe_reg <= 1'b0;
				end
			endcase
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	property p_low_only;
		sda_oe_reg |-> (sda_out_reg == 1'b0);
	endproperty
	a_low_only: assert property (p_low_only)
		else $error("data line driven high");

	property p_oe_on_fall;
		$changed(sda_oe_reg) |-> $past(scl_fall || start_det || stop_det);
	endproperty
	a_oe_on_fall: assert property (p_oe_on_fall)
		else $error("data line changed off a falling clock");

	property p_start_abort;
		start_det |=> (state_reg == ST_ADDR) && !sda_oe_reg &&
			(bit_reg == BIT_ZERO);
	endproperty
	a_start_abort: assert property (p_start_abort)
		else $error("start did not restart the engine");

	property p_stop_abort;
		stop_det |=> (state_reg == ST_IDLE) && !sda_oe_reg;
	endproperty
	a_stop_abort: assert property (p_stop_abort)
		else $error("stop did not idle the engine");

	property p_no_match;
		scl_fall && edge_ok && (state_reg == ST_ADDR) &&
			(bit_reg == BIT_ACK) && !sel_match
			|=> (state_reg == ST_IDLE) && !sda_oe_reg;
	endproperty
	a_no_match: assert property (p_no_match)
		else $error("acknowledged a foreign address");

	property p_addr_fields;
		scl_fall && edge_ok && (state_reg == ST_ADDR) &&
			(bit_reg == BIT_ACK) && sel_match
			|=> sda_oe_reg && (rw_reg == $past(shift_reg[0])) &&
			(page_reg == $past(shift_reg[1]));
	endproperty
	a_addr_fields: assert property (p_addr_fields)
		else $error("slave byte fields not latched");

	property p_commit;
		wr_en |=> mem_reg[$past(addr_reg)] == $past(shift_reg);
	endproperty
	a_commit: assert property (p_commit)
		else $error("byte not committed at once");

	property p_locked;
		wr_fire && lock_s |=>
			mem_reg[$past(addr_reg)] == $past(mem_reg[addr_reg]);
	endproperty
	a_locked: assert property (p_locked)
		else $error("locked array changed");

	property p_wrap;
		wr_fire && (addr_reg == 9'h1FF) |=> addr_reg == 9'h000;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("address did not wrap");

	property p_step;
		wr_fire && (addr_reg != 9'h1FF) |=>
			addr_reg == $past(addr_reg) + 9'h001;
	endproperty
	a_step: assert property (p_step)
		else $error("address did not step by one");

	property p_bit_range;
		bit_reg <= 4'h9;
	endproperty
	a_bit_range: assert property (p_bit_range)
		else $error("bit counter out of range");

	property p_read_nack;
		scl_fall && edge_ok && (state_reg == ST_RDATA) &&
			(bit_reg == BIT_END) && !mack_reg
			|=> (state_reg == ST_IDLE) ##1 !sda_oe_reg;
	endproperty
	a_read_nack: assert property (p_read_nack)
		else $error("read went on after master nack");

	property p_oe_busy;
		sda_oe_reg |-> (state_reg != ST_IDLE);
	endproperty
	a_oe_busy: assert property (p_oe_busy)
		else $error("data line pulled while idle");

	property p_rx_shift;
		scl_rise && (bit_reg < BIT_ACK) &&
			((state_reg == ST_ADDR) || (state_reg == ST_WORD) ||
			(state_reg == ST_WDATA))
			|=> (shift_reg[0] == $past(sda_s)) &&
			(bit_reg == $past(bit_reg) + 4'h1);
	endproperty
	a_rx_shift: assert property (p_rx_shift)
		else $error("input bit not taken on rising clock");

	property p_word_latch;
		scl_fall && edge_ok && (state_reg == ST_WORD) &&
			(bit_reg == BIT_ACK)
			|=> sda_oe_reg && (addr_reg == {page_reg, $past(shift_reg)});
	endproperty
	a_word_latch: assert property (p_word_latch)
		else $error("word address not latched");

	property p_rd_first;
		scl_fall && edge_ok && (state_reg == ST_ADDR) &&
			(bit_reg == BIT_END) && (rw_reg == RW_READ)
			|=> (state_reg == ST_RDATA) &&
			(sda_oe_reg == !tx_reg[BYTE_W-1]);
	endproperty
	a_rd_first: assert property (p_rd_first)
		else $error("read did not start with the first bit");
endmodule

// *** include/ifsm_pkg.sv ***
// Shared constants and types for the two-wire nonvolatile memory slave
package ifsm_pkg;
	localparam int MEM_DEPTH   = 512;
	localparam int ADDR_W      = 9;
	localparam int BYTE_W      = 8;
	localparam int PAGE_DEPTH  = 256;
	localparam int SEL_W       = 2;
	localparam int TYPE_W      = 4;
	localparam int SYNC_W      = 5;

	// Slave address byte layout
	localparam int SA_TYPE_MSB = 7;
	localparam int SA_TYPE_LSB = 4;
	localparam int SA_SEL_MSB  = 3;
	localparam int SA_SEL_LSB  = 2;
	localparam int SA_PAGE_BIT = 1;
	localparam int SA_RW_BIT   = 0;
	localparam logic RW_READ   = 1'b1;

	// Bit counter marks: eight data clocks, then the ninth
	localparam logic [3:0] BIT_ZERO = 4'h0;
	localparam logic [3:0] BIT_ACK  = 4'h8;
	localparam logic [3:0] BIT_END  = 4'h9;

	localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;
	localparam logic [ADDR_W-1:0] ADDR_LAST  = 9'h1FF;
	localparam logic [ADDR_W-1:0] ADDR_ONE   = 9'h001;
	localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;

	// Timing: fastest serial clock against the system clock
	localparam int MCLK_PERIOD_NS  = 20;
	localparam int SCL_MIN_PERIOD_NS = 1000;
	localparam int SCL_HALF_CYC =
		SCL_MIN_PERIOD_NS / 2 / MCLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_WORD,
		ST_WDATA,
		ST_RDATA
	} ifsm_state_t;

	function automatic logic [ADDR_W-1:0] next_addr(
		input logic [ADDR_W-1:0] a);
		next_addr = (a == ADDR_LAST) ? ADDR_RESET : a + ADDR_ONE;
	endfunction
endpackage

// *** verification/ifsm_master.sv ***
// Bus master model driving the memory slave's serial pins
module ifsm_master #(
	parameter int HALF = 11 // Phase in lclk, near 1 MHz
) (
	input  wire logic lclk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      m_low
);
	timeunit 1ns;
	timeprecision 1ns;
	// Clock stands high between frames, as the pull-up leaves it
	initial begin
		scl = 1'b1;
		m_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge lclk);
	endtask
	task automatic bit_io(input logic b, output logic got);
		tick(1);
		m_low <= !b; // Data moves only while clock low
		tick(HALF - 1);
		scl <= 1'b1;
		tick(HALF);
		got = sda_line;
		scl <= 1'b0;
	endtask
	task automatic start_cond();
		tick(1);
		m_low <= 1'b0;
		tick(HALF);
		scl <= 1'b1;
		tick(HALF);
		m_low <= 1'b1;
		tick(HALF);
		scl <= 1'b0;
	endtask
	task automatic stop_cond();
		tick(1);
		m_low <= 1'b1;
		tick(HALF);
		scl <= 1'b1;
		tick(HALF);
		m_low <= 1'b0;
		tick(HALF);
	endtask
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic x;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], x);
		end
		bit_io(1'b1, x);
		ack = !x;
	endtask
	task automatic send_addr(input logic [3:0] t, input logic [1:0] s,
		input logic p, input logic rw, output logic ack);
		send_byte({t, s, p, rw}, ack);
	endtask
	task automatic recv_byte(input logic more, output logic [7:0] d);
		logic x;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(!more, x); // Withheld ack ends the read
	endtask
endmodule

// *** verification/ifsm_top_test.sv ***
// Self-checking bench for the two-wire memory slave
module ifsm_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	import ifsm_pkg::*;
	localparam logic [3:0] TYPE  = 4'h3; // Arbitrary type code
	localparam int         LIMIT = 60000;
	logic                mclk, lclk, rst_n, sda_out, sda_oe, wr_lock;
	logic                scl, m_low, ack, sda_line;
	logic [SEL_W-1:0]    cs;
	logic [ADDR_W-1:0]   base;
	logic [BYTE_W-1:0]   mem_ref [MEM_DEPTH];
	int                  mismatches, samples_checked, cycles;
	// Pull-up wins unless a party pulls low
	assign sda_line = !(m_low || (sda_oe && !sda_out));
	ifsm_top #(.DEV_TYPE(TYPE)) i_dut (.mclk(mclk), .rst_n(rst_n),
		.scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe(sda_oe), .chip_select_pins(cs), .wr_lock(wr_lock));
	ifsm_master i_master (.lclk(lclk), .sda_line(sda_line), .scl(scl),
		.m_low(m_low));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// Odd offset keeps the link clock unrelated in phase
	initial begin
		lclk = 1'b0;
		#7;
		forever #24 lclk = ~lclk;
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == LIMIT) begin
			mismatches++;
			final_report();
		end
	end
	task automatic chk_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask
	task automatic pins(input logic l, input logic [SEL_W-1:0] c);
		@(posedge mclk);
		wr_lock <= l;
		cs <= c;
		repeat (6) @(posedge mclk);
	endtask
	task automatic done(input string name);
		chk_bit(sda_oe, 1'b0);
		$display("test %0s done", name);
	endtask
	task automatic wr(input logic [8:0] a, input int n, input logic stp);
		logic [7:0] d;
		i_master.start_cond();
		i_master.send_addr(TYPE, cs, a[8], 1'b0, ack);
		chk_bit(ack, 1'b1);
		i_master.send_byte(a[7:0], ack);
		chk_bit(ack, 1'b1);
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			i_master.send_byte(d, ack);
			chk_bit(ack, 1'b1);
			if (wr_lock !== 1'b1) mem_ref[a] = d;
			a = a + 9'h001;
		end
		if (stp) i_master.stop_cond();
	endtask
	task automatic rd(input logic [8:0] a, input int n, input logic rs);
		logic [7:0] d;
		wr(a, 0, !rs);
		i_master.start_cond();
		i_master.send_addr(TYPE, cs, a[8], 1'b1, ack);
		chk_bit(ack, 1'b1);
		for (int i = 0; i < n; i++) begin
			i_master.recv_byte(i < n - 1, d);
			chk_byte(d, mem_ref[a]);
			a = a + 9'h001;
		end
		i_master.stop_cond();
	endtask
	initial begin
		logic b;
		rst_n = 1'b0;
		wr_lock = 1'b0;
		cs = '0;
		mismatches = 0;
		samples_checked = 0;
		cycles = 0;
		void'($urandom(32'hD993C93D));
		repeat (20) @(posedge mclk);
		chk_bit(sda_oe, 1'b0);
		rst_n <= 1'b1;
		repeat (10) @(posedge mclk);
		// Unconnected pins resolve low, as the pull-downs hold them
		pins(1'b0, 2'h0);
		base = 9'($urandom);
		wr(base, 4, 1'b1);
		rd(base, 4, 1'b0);
		done("float");
		pins(1'b0, 2'($urandom));
		for (int s = 0; s < 4; s++) begin
			i_master.start_cond();
			i_master.send_addr(TYPE, 2'(s), 1'b0, 1'b0, ack);
			chk_bit(ack, 2'(s) == cs);
			i_master.stop_cond();
		end
		i_master.start_cond();
		i_master.send_addr(TYPE ^ 4'h1, cs, 1'b0, 1'b0, ack);
		chk_bit(ack, 1'b0);
		i_master.stop_cond();
		done("select");
		pins(1'b1, cs);
		wr(base, 3, 1'b1);
		pins(1'b0, cs);
		rd(base, 3, 1'b1);
		done("lock");
		// Back-to-back, no polling, across the top address
		wr(9'h1FF, 2, 1'b0);
		rd(9'h1FF, 2, 1'b1);
		done("wrap");
		// Start or stop in mid-byte leaves the array untouched
		for (int k = 0; k < 2; k++) begin
			i_master.start_cond();
			i_master.send_addr(TYPE, cs, base[8], 1'b0, ack);
			i_master.send_byte(base[7:0], ack);
			for (int i = 0; i < 3; i++) i_master.bit_io(1'($urandom), b);
			if (k == 1) begin
				i_master.stop_cond();
				// All ones: no data edge while the clock stands high
				i_master.send_byte(8'hFF, ack);
				chk_bit(ack, 1'b0);
				i_master.stop_cond();
			end
			rd(base, 1, k == 0);
		end
		done("abort");
		for (int k = 0; k < 3; k++) begin
			base = 9'($urandom);
			b = 1'($urandom);
			wr(base, 1 + ($urandom % 6), b);
			rd(base, 1, !b);
		end
		done("random");
		final_report();
	end
endmodule
